/* msc_accum.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_accum
	import msc_pkg::*;
#(
	parameter int ACC_WIDTH = msc_pkg::ACC_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clr,
	input wire logic [msc_pkg::N_CH-1:0] add_en,
	input wire logic [msc_pkg::N_CH-1:0][msc_pkg::DATA_W-1:0] sample,
	input wire logic [msc_pkg::AVG_W-1:0] avg_log2,
	output logic [msc_pkg::N_CH-1:0][msc_pkg::DATA_W-1:0] avg
);
	if (ACC_WIDTH < DATA_W + AVG_LOG2_MAX + 1)
	begin : g_chk
		$error("msc_accum: accumulator too narrow");
	end

	for (genvar g = 0; g < N_CH; g++)
	begin : g_ch
		logic signed [ACC_WIDTH-1:0] sum_r;
		logic signed [ACC_WIDTH-1:0] quot;
		always_ff @(posedge clk)
		begin
			if (!resetn || clr)
				sum_r <= '0;
			else if (add_en[g])
				sum_r <= sum_r + {{(ACC_WIDTH-DATA_W){sample[g][DATA_W-1]}}, sample[g]};
		end
		// Count is a power of two, so the average is an arithmetic shift
		assign quot = sum_r >>> avg_log2;
		assign avg[g] = quot[DATA_W-1:0];
	end
endmodule : msc_accum
`default_nettype wire

/* msc_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_adc_model
	import msc_pkg::*;
(
	input wire logic clk,
	input wire logic restart,
	input wire logic [7:0] delay,
	input wire logic [15:0] sh_base,
	input wire logic [15:0] bu_base,
	input wire logic start,
	input wire logic ch,
	output logic done,
	output logic [15:0] data
);
	int cnt = -1;
	int hi = 0;
	int sh_i = 0;
	int bu_i = 0;
	logic ch_r = 1'b0;
	always @(posedge clk)
	begin
		// Restart also parks the pins, so they are known while the sequencer is in reset
		if (restart)
		begin
			sh_i = 0;
			bu_i = 0;
			done <= 1'b0;
			data <= 16'h0;
		end
		if (start)
		begin
			// A new start abandons any conversion still running
			ch_r = ch;
			cnt = delay;
			hi = 0;
			done <= 1'b0;
			data <= ~data;
		end
		else if (cnt > 0)
			cnt = cnt - 1;
		else if (cnt == 0)
		begin
			// Bit 15 set on bus data: the result must drop it
			data <= ch_r ? (16'h8000 | (bu_base + 16'(bu_i))) : (sh_base + 16'(sh_i));
			if (ch_r)
				bu_i++;
			else
				sh_i++;
			cnt = -1;
			hi = 4;
		end
		else if (hi > 0)
		begin
			done <= hi > 1;
			hi = hi - 1;
		end
	end
endmodule : msc_adc_model
`default_nettype wire

/* msc_math.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_math
	import msc_pkg::*;
(
	input wire logic [msc_pkg::DATA_W-1:0] shunt,
	input wire logic [msc_pkg::DATA_W-1:0] bus,
	input wire logic [msc_pkg::CAL_W-1:0] cal,
	input wire logic cal_loaded,
	input wire logic [msc_pkg::DATA_W-1:0] cur_prev,
	output logic [msc_pkg::DATA_W-1:0] current,
	output logic [msc_pkg::DATA_W-1:0] power
);
	logic signed [DATA_W+CAL_W:0] cur_full;
	logic signed [DATA_W+CAL_W:0] cur_sh;
	logic signed [2*DATA_W:0] pwr_full;
	logic signed [2*DATA_W:0] pwr_sh;

	// Purely combinational so results are ready in the capture cycle
	assign cur_full = $signed(shunt) * $signed({1'b0, cal});
	assign cur_sh = cur_full >>> CUR_SHIFT;
	assign pwr_full = $signed(cur_prev) * $signed({1'b0, bus});
	assign pwr_sh = pwr_full >>> PWR_SHIFT;
	assign current = cal_loaded ? cur_sh[DATA_W-1:0] : '0;
	assign power = cal_loaded ? pwr_sh[DATA_W-1:0] : '0;
endmodule : msc_math
`default_nettype wire

/* msc_pkg.sv */
// How it works
// - Continuous mode repeats shunt then bus conversions with no host action.
// - Each shunt sample yields a current scaled by the calibration value.
// - Power uses the latest current and the bus sample.
// - Samples and derived values accumulate until the averaging count is met.
// - Without a loaded calibration value, current and power are zero.
// - Output values load only once averaging has completed.
// - Output values hold until the next complete result set.
// - Reading results never disturbs a conversion in progress.
// - Mode codes also allow shunt-only or bus-only conversion.
// - Current and power math runs alongside conversion, adding no time.
// - Writing a triggered mode starts exactly one measurement set.
// - Power-down stops conversions until an active mode is written.
// - Leaving power-down needs a recovery interval before valid conversions.
// - Registers stay writable and readable while powered down.
// - Conversion-ready sets when a whole cycle, averaging and math included, ends.
// - A mode write clears conversion-ready unless it selects power-down.
// - Reading the status clears conversion-ready.
// - Bus result uses a fixed 1.25 mV step, full scale 40.96 V.
`default_nettype none
package msc_pkg;
	localparam logic [2:0] MODE_PD0 = 3'h0;
	localparam logic [2:0] MODE_SHUNT_TRIG = 3'h1;
	localparam logic [2:0] MODE_BUS_TRIG = 3'h2;
	localparam logic [2:0] MODE_BOTH_TRIG = 3'h3;
	localparam logic [2:0] MODE_PD1 = 3'h4;
	localparam logic [2:0] MODE_BOTH_CONT = 3'h7;
	localparam int MODE_BIT_SHUNT = 0;
	localparam int MODE_BIT_BUS = 1;
	localparam int MODE_BIT_CONT = 2;
	localparam logic [2:0] RESET_MODE = MODE_BOTH_CONT;
	localparam int DATA_W = 16;
	localparam int CAL_W = 16;
	localparam int ACC_W = 32;
	localparam int AVG_W = 4;
	localparam int AVG_LOG2_MAX = 10;
	localparam int SAMP_W = AVG_LOG2_MAX + 1;
	localparam int CUR_SHIFT = 11;
	localparam int PWR_SHIFT = 13;
	localparam int CLK_HZ = 200_000_000;
	localparam int RECOVERY_MS = 40;
	localparam int RECOVERY_CYCLES = RECOVERY_MS * (CLK_HZ / 1000);
	localparam int BUS_LSB_UV = 1250;
	localparam int BUS_FULL_SCALE_MV = 40960;
	localparam int BUS_CODE_W = 15;
	localparam int CH_SHUNT = 0;
	localparam int CH_BUS = 1;
	localparam int CH_CUR = 2;
	localparam int CH_PWR = 3;
	localparam int N_CH = 4;

	typedef struct packed {
		logic [DATA_W-1:0] shunt;
		logic [DATA_W-1:0] bus;
		logic [DATA_W-1:0] current;
		logic [DATA_W-1:0] power;
	} msc_result_s;

	typedef enum logic [5:0] {
		ST_PD = 6'h01,
		ST_REC = 6'h02,
		ST_IDLE = 6'h04,
		ST_SHUNT = 6'h08,
		ST_BUS = 6'h10,
		ST_DONE = 6'h20
	} msc_state_e;

	function automatic logic msc_is_pd(input logic [2:0] m);
		return m[1:0] == 2'h0;
	endfunction : msc_is_pd
endpackage : msc_pkg
`default_nettype wire

/* msc_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module msc_sequencer
	import msc_pkg::*;
#(
	parameter int RECOVERY_CYCLES_P = msc_pkg::RECOVERY_CYCLES
)
(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CFG_WR,
	input wire logic [2:0] CFG_MODE,
	input wire logic [msc_pkg::AVG_W-1:0] AVG_LOG2,
	input wire logic CAL_WR,
	input wire logic [msc_pkg::CAL_W-1:0] CAL_VAL,
	input wire logic STATUS_RD,
	input wire logic ADC_DONE,
	input wire logic [msc_pkg::DATA_W-1:0] ADC_DATA,
	output logic ADC_START,
	output logic ADC_CH,
	output msc_pkg::msc_result_s RESULT,
	output logic CONV_READY,
	output logic BUSY,
	output logic POWERED_DOWN
);
	if (RECOVERY_CYCLES_P < 1)
	begin : g_chk_rec
		$error("msc_sequencer: recovery count must be at least one");
	end
	if (BUS_LSB_UV * (1 << BUS_CODE_W) != BUS_FULL_SCALE_MV * 1000)
	begin : g_chk_bus
		$error("msc_sequencer: bus code width does not match full scale");
	end

	msc_state_e st_r;
	logic [2:0] mode_r;
	logic [AVG_W-1:0] avg_r;
	logic [CAL_W-1:0] cal_r;
	logic cal_loaded_r;
	logic trig_r;
	logic ready_r;
	logic [31:0] rec_cnt_r;
	logic [SAMP_W-1:0] samp_cnt_r;
	logic [DATA_W-1:0] current_r;
	logic adc_start_r;
	logic adc_ch_r;
	msc_result_s res_r;
	logic done_s1, done_s2, done_s3;
	logic [DATA_W-1:0] data_s1, data_s2;
	logic adc_evt;
	logic cont;
	logic first_bus;
	logic start_cycle;
	logic shunt_cap;
	logic bus_cap;
	logic sample_end;
	logic last;
	logic launch_nxt;
	logic ch_nxt;
	logic [DATA_W-1:0] bus_code;
	logic [DATA_W-1:0] cur_calc;
	logic [DATA_W-1:0] pwr_calc;
	logic [N_CH-1:0] add_en;
	logic [N_CH-1:0][DATA_W-1:0] sample;
	logic [N_CH-1:0][DATA_W-1:0] avg;

	// Conversion data and done arrive from the converter's domain
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
			data_s1 <= '0;
			data_s2 <= '0;
		end
		else
		begin
			done_s1 <= ADC_DONE;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
			data_s1 <= ADC_DATA;
			data_s2 <= data_s1;
		end
	end

	assign adc_evt = done_s2 & ~done_s3;
	assign cont = mode_r[MODE_BIT_CONT] & ~msc_is_pd(mode_r);
	assign first_bus = ~mode_r[MODE_BIT_SHUNT];
	assign start_cycle = (st_r == ST_IDLE) && (cont || trig_r) && !CFG_WR;
	assign shunt_cap = (st_r == ST_SHUNT) && adc_evt && !CFG_WR;
	assign bus_cap = (st_r == ST_BUS) && adc_evt && !CFG_WR;
	assign sample_end = (shunt_cap && !mode_r[MODE_BIT_BUS]) || bus_cap;
	assign last = samp_cnt_r == SAMP_W'((32'd1 << avg_r) - 32'd1);
	assign launch_nxt = start_cycle || (shunt_cap && mode_r[MODE_BIT_BUS]) || (sample_end && !last);
	assign ch_nxt = (shunt_cap && mode_r[MODE_BIT_BUS]) ? 1'b1 : first_bus;
	// Bus code keeps only the bits that span full scale at the fixed step
	assign bus_code = {{(DATA_W-BUS_CODE_W){1'b0}}, data_s2[BUS_CODE_W-1:0]};

	msc_math u_math (
		.shunt(data_s2),
		.bus(bus_code),
		.cal(cal_r),
		.cal_loaded(cal_loaded_r),
		.cur_prev(current_r),
		.current(cur_calc),
		.power(pwr_calc)
	);

	// Raw samples feed the sums in the capture cycle, so averaging adds no latency
	assign add_en[CH_SHUNT] = shunt_cap;
	assign add_en[CH_CUR] = shunt_cap;
	assign add_en[CH_BUS] = bus_cap;
	assign add_en[CH_PWR] = bus_cap;
	assign sample[CH_SHUNT] = data_s2;
	assign sample[CH_CUR] = cur_calc;
	assign sample[CH_BUS] = bus_code;
	assign sample[CH_PWR] = pwr_calc;

	msc_accum u_accum (
		.clk(REF_CLK),
		.resetn(RESETN),
		.clr(start_cycle),
		.add_en(add_en),
		.sample(sample),
		.avg_log2(avg_r),
		.avg(avg)
	);

	// Configuration is accepted in every state, power-down included
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			mode_r <= RESET_MODE;
			avg_r <= '0;
		end
		else if (CFG_WR)
		begin
			mode_r <= CFG_MODE;
			avg_r <= (AVG_LOG2 > AVG_W'(AVG_LOG2_MAX)) ? AVG_W'(AVG_LOG2_MAX) : AVG_LOG2;
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			cal_r <= '0;
			cal_loaded_r <= 1'b0;
		end
		else if (CAL_WR)
		begin
			cal_r <= CAL_VAL;
			cal_loaded_r <= 1'b1;
		end
	end

	// Each write of a triggered code arms one set, even if the code is unchanged
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
			trig_r <= 1'b0;
		else if (CFG_WR)
			trig_r <= ~CFG_MODE[MODE_BIT_CONT] & ~msc_is_pd(CFG_MODE);
		else if (start_cycle)
			trig_r <= 1'b0;
	end

	// A mode write aborts the set in flight; a late done from it is ignored only until the next set enters ST_SHUNT or ST_BUS
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
			st_r <= msc_is_pd(RESET_MODE) ? ST_PD : ST_IDLE;
		else if (CFG_WR)
		begin
			if (msc_is_pd(CFG_MODE))
				st_r <= ST_PD;
			else if (st_r == ST_PD || st_r == ST_REC)
				st_r <= ST_REC;
			else
				st_r <= ST_IDLE;
		end
		else
		begin
			case (st_r)
				ST_PD: st_r <= ST_PD;
				ST_REC: if (rec_cnt_r == 32'(RECOVERY_CYCLES_P - 1)) st_r <= ST_IDLE;
				ST_IDLE: if (start_cycle) st_r <= first_bus ? ST_BUS : ST_SHUNT;
				ST_SHUNT:
					if (shunt_cap)
						st_r <= mode_r[MODE_BIT_BUS] ? ST_BUS : (last ? ST_DONE : ST_SHUNT);
				ST_BUS:
					if (bus_cap)
						st_r <= last ? ST_DONE : (first_bus ? ST_BUS : ST_SHUNT);
				ST_DONE: st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN || CFG_WR || st_r != ST_REC)
			rec_cnt_r <= '0;
		else
			rec_cnt_r <= rec_cnt_r + 32'h1;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN || start_cycle)
			samp_cnt_r <= '0;
		else if (sample_end && !last)
			samp_cnt_r <= samp_cnt_r + SAMP_W'(1);
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
			current_r <= '0;
		else if (shunt_cap)
			current_r <= cur_calc;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
		begin
			adc_start_r <= 1'b0;
			adc_ch_r <= 1'b0;
		end
		else
		begin
			adc_start_r <= launch_nxt;
			if (launch_nxt)
				adc_ch_r <= ch_nxt;
		end
	end

	// Results change only here; there is no read path back into the sequencer
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
			res_r <= '0;
		else if (st_r == ST_DONE)
		begin
			if (mode_r[MODE_BIT_SHUNT])
			begin
				res_r.shunt <= avg[CH_SHUNT];
				res_r.current <= avg[CH_CUR];
			end
			if (mode_r[MODE_BIT_BUS])
			begin
				res_r.bus <= avg[CH_BUS];
				res_r.power <= avg[CH_PWR];
			end
		end
	end

	// Setting wins over a clear landing in the same cycle
	always_ff @(posedge REF_CLK)
	begin
		if (!RESETN)
			ready_r <= 1'b0;
		else if (st_r == ST_DONE)
			ready_r <= 1'b1;
		else if ((CFG_WR && !msc_is_pd(CFG_MODE)) || STATUS_RD)
			ready_r <= 1'b0;
	end

	assign ADC_START = adc_start_r;
	assign ADC_CH = adc_ch_r;
	assign RESULT = res_r;
	assign CONV_READY = ready_r;
	assign BUSY = (st_r == ST_SHUNT) || (st_r == ST_BUS) || (st_r == ST_DONE);
	assign POWERED_DOWN = st_r == ST_PD;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);

	property p_cont_restart;
		(st_r == ST_DONE && cont && !CFG_WR) ##1 !CFG_WR |-> ##1 ADC_START;
	endproperty
	a_cont_restart: assert property (p_cont_restart) else $error("continuous mode did not restart");
	property p_single_shot;
		(st_r == ST_DONE && !cont && !CFG_WR) ##1 !CFG_WR [*3] |-> !ADC_START && st_r == ST_IDLE;
	endproperty
	a_single_shot: assert property (p_single_shot) else $error("triggered mode kept converting");

	property p_current_calc;
		shunt_cap |=> current_r == $past(cur_calc);
	endproperty
	a_current_calc: assert property (p_current_calc) else $error("current not taken at shunt sample");
	property p_no_cal_zero;
		(shunt_cap && !cal_loaded_r) |=> current_r == '0;
	endproperty
	a_no_cal_zero: assert property (p_no_cal_zero) else $error("current nonzero without calibration");

	property p_hold_results;
		st_r != ST_DONE |=> $stable(res_r);
	endproperty
	a_hold_results: assert property (p_hold_results) else $error("results changed outside completion");
	property p_pd_stays;
		(st_r == ST_PD && !CFG_WR) |=> st_r == ST_PD && !ADC_START;
	endproperty
	a_pd_stays: assert property (p_pd_stays) else $error("left power-down without a write");

	property p_rec_hold;
		st_r == ST_REC |-> !ADC_START && !BUSY;
	endproperty
	a_rec_hold: assert property (p_rec_hold) else $error("conversion during recovery");
	property p_ready_set;
		st_r == ST_DONE |=> CONV_READY;
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ready not set at completion");

	property p_ready_cfg_clr;
		(CFG_WR && !msc_is_pd(CFG_MODE) && st_r != ST_DONE) |=> !CONV_READY;
	endproperty
	a_ready_cfg_clr: assert property (p_ready_cfg_clr) else $error("mode write left ready set");
	property p_ready_rd_clr;
		(STATUS_RD && st_r != ST_DONE) |=> !CONV_READY;
	endproperty
	a_ready_rd_clr: assert property (p_ready_rd_clr) else $error("status read left ready set");
	property p_bus_range;
		RESULT.bus[DATA_W-1:BUS_CODE_W] == '0;
	endproperty
	a_bus_range: assert property (p_bus_range) else $error("bus result above full scale");

	c_cont_done: cover property (st_r == ST_DONE && cont);
	c_trig_done: cover property (st_r == ST_DONE && !cont);
	c_rec_exit: cover property (st_r == ST_REC ##1 st_r == ST_IDLE);
	c_read_clear: cover property (CONV_READY && STATUS_RD ##1 !CONV_READY);
endmodule : msc_sequencer
`default_nettype wire

/* test_monitor_conversion_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_monitor_conversion_sequencer import msc_pkg::*;;
	localparam int REC = 20;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cfg_wr = 1'b0;
	logic [2:0] cfg_mode = 3'h7;
	logic [AVG_W-1:0] avg_log2 = '0;
	logic cal_wr = 1'b0;
	logic [CAL_W-1:0] cal_val = '0;
	logic status_rd = 1'b0;
	logic restart = 1'b1;
	logic [7:0] delay = 8'h6;
	logic [15:0] sh_base = 16'h10;
	logic [15:0] bu_base = 16'h100;
	logic adc_done;
	logic adc_start;
	logic adc_ch;
	logic conv_ready;
	logic busy;
	logic pwr_dn;
	logic [15:0] adc_data;
	msc_result_s result;
	msc_result_s exp_r = '0;
	logic [3:0] known = 4'hf;
	logic [2:0] modes [7] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h3};
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int starts = 0;
	int cal_int = 0;
	int s;
	int lg;
	bit cal_ok = 0;

	always #2.5 clk = ~clk;

	msc_sequencer #(.RECOVERY_CYCLES_P(REC)) u_msc_sequencer (.REF_CLK(clk), .RESETN(resetn),
		.CFG_WR(cfg_wr), .CFG_MODE(cfg_mode), .AVG_LOG2(avg_log2), .CAL_WR(cal_wr),
		.CAL_VAL(cal_val), .STATUS_RD(status_rd), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
		.ADC_START(adc_start), .ADC_CH(adc_ch), .RESULT(result), .CONV_READY(conv_ready),
		.BUSY(busy), .POWERED_DOWN(pwr_dn));

	msc_adc_model u_msc_adc_model (.clk(clk), .restart(restart), .delay(delay),
		.sh_base(sh_base), .bu_base(bu_base), .start(adc_start), .ch(adc_ch),
		.done(adc_done), .data(adc_data));

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	always @(posedge clk)
	begin
		cycles++;
		if (adc_start === 1'b1)
			starts++;
		if (cycles == 60000)
		begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Only fields the model can predict are compared
	task automatic cmp_res();
		if (known[3])
			chk(result.shunt, exp_r.shunt);
		if (known[2])
			chk(result.bus, exp_r.bus);
		if (known[1])
			chk(result.current, exp_r.current);
		if (known[0])
			chk(result.power, exp_r.power);
	endtask : cmp_res

	task automatic expect_set(input logic [2:0] m, input int lg2, input int ofs);
		int n = 1 << lg2;
		int ss = 0;
		int bs = 0;
		int cs = 0;
		int ps = 0;
		int sh;
		int bu;
		int cu;
		for (int i = 0; i < n; i++)
		begin
			sh = sh_base + ofs + i;
			bu = bu_base + ofs + i;
			cu = cal_ok ? ((sh * cal_int) >>> 11) : 0;
			ss += sh;
			bs += bu;
			cs += cu;
			ps += cal_ok ? ((cu * bu) >>> 13) : 0;
		end
		if (m[0])
		begin
			exp_r.shunt = 16'(ss >> lg2);
			exp_r.current = 16'(cs >> lg2);
		end
		if (m[1])
			exp_r.bus = 16'(bs >> lg2);
		exp_r.power = 16'(ps >> lg2);
		known = {known[3] | m[0], known[2] | m[1], known[1] | m[0], m[1:0] == 2'h3};
	endtask : expect_set

	task automatic wait_ready();
		int k = 0;
		while (conv_ready !== 1'b1 && k < 5000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 5000)
		begin
			err_count++;
			$display("mismatch at %0t: no result set completed", $time);
		end
	endtask : wait_ready

	// Writes land just after a start so no converter answer is in flight
	task automatic cfg(input logic [2:0] m, input int lg2);
		int k = 0;
		while (busy === 1'b1 && adc_start !== 1'b1 && k < 500)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 500)
		begin
			err_count++;
			$display("mismatch at %0t: no safe point for a mode write", $time);
		end
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_mode <= m;
		avg_log2 <= AVG_W'(lg2);
		restart <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		restart <= 1'b0;
		@(posedge clk);
	endtask : cfg

	task automatic load_cal();
		@(posedge clk);
		cal_int = $urandom_range(4095, 1);
		cal_val <= CAL_W'(cal_int);
		cal_wr <= 1'b1;
		cal_ok = 1;
		@(posedge clk);
		cal_wr <= 1'b0;
	endtask : load_cal

	initial
	begin
		void'($urandom(72713));
		repeat (16) @(posedge clk);
		chk(result.shunt | result.power, 16'h0);
		chk({15'h0, conv_ready | adc_start | pwr_dn | busy}, 16'h0);
		resetn <= 1'b1;
		restart <= 1'b0;
		expect_set(3'h7, 0, 0);
		wait_ready();
		cmp_res();
		status_rd <= 1'b1;
		@(posedge clk);
		status_rd <= 1'b0;
		@(posedge clk);
		chk({15'h0, conv_ready}, 16'h0);
		expect_set(3'h7, 0, 1);
		wait_ready();
		cmp_res();
		load_cal();
		foreach (modes[j])
		begin
			lg = $urandom_range(2, 0);
			sh_base <= 16'($urandom_range(1000, 1));
			bu_base <= 16'($urandom_range(8000, 1));
			delay <= 8'($urandom_range(25, 6));
			cfg(modes[j], lg);
			chk({15'h0, conv_ready}, 16'h0);
			expect_set(modes[j], lg, 0);
			wait_ready();
			cmp_res();
			if (!modes[j][2])
			begin
				s = starts;
				repeat (100) @(posedge clk);
				chk(16'(starts - s), 16'h0);
				chk({15'h0, busy}, 16'h0);
				cmp_res();
			end
		end
		cfg(3'h0, 0);
		chk({14'h0, conv_ready, pwr_dn}, 16'h3);
		load_cal();
		s = starts;
		repeat (200) @(posedge clk);
		chk(16'(starts - s), 16'h0);
		// The second power-down code must behave exactly like the first
		cfg(3'h4, 0);
		chk({14'h0, conv_ready, pwr_dn}, 16'h3);
		cfg(3'h7, 1);
		s = starts;
		repeat (REC) @(posedge clk);
		chk(16'(starts - s), 16'h0);
		expect_set(3'h7, 1, 0);
		wait_ready();
		cmp_res();
		complete_run();
	end
endmodule : test_monitor_conversion_sequencer
`default_nettype wire
